// ===== src/adc_ctl_pkg.sv
// Shared constants for the sampling converter control block and its host end.
// Assumes one 50 MHz clock that both ends share as the conversion clock.
package adc_ctl_pkg;
  localparam int unsigned RESULT_W      = 10;             // Result width
  localparam int unsigned LOW_W         = 8;              // Low byte width
  localparam int unsigned HIGH_W        = 2;              // High part width
  localparam int unsigned CONV_CLKS     = 46;             // Clocks after start strobe
  localparam int unsigned READ_CLKS     = 4;              // Clocks budgeted for readout
  localparam int unsigned MIN_SPACING   = 50;             // Least strobe spacing
  localparam int unsigned SPACING_STEP  = 4;              // Spacing granularity
  localparam int unsigned DIV_SIMPLE    = 64;             // Simple divider ratio
  localparam int unsigned DIV_TIMER     = 52;             // Timer divider ratio
  localparam int unsigned CNT_W         = 8;              // Counter width
  localparam logic        ADDR_BASE     = 1'b0;           // Low byte or full word
  localparam logic        ADDR_HIGH     = 1'b1;           // High bits and status
  localparam int unsigned STATUS_BIT    = 7;              // Done flag in high byte
  localparam logic [7:0]  DATA_ZERO     = 8'h00;
endpackage : adc_ctl_pkg

// ===== src/adc_bus_if.sv
// Parallel bus between host and converter, with the two open-drain outputs.
// Assumes both ends run on the same clock; the open-drain wires resolve here.
`timescale 1ns/1ps
`default_nettype none
interface adc_bus_if;
  logic       cs_n;        // Chip select, active low
  logic       wr_n;        // Start strobe, active low
  logic       rd_n;        // Read strobe, active low
  logic       addr;        // Address bit 0
  logic [9:0] data;        // Read data from the converter
  logic       int_oe;      // Converter pulls interrupt low
  logic       rdy_oe;      // Converter pulls ready low
  logic       int_n;       // Resolved interrupt wire, pulled up
  logic       rdy;         // Resolved ready wire, pulled up

  // Pull-ups: a wire is low only while someone drives it
  assign int_n = ~int_oe;
  assign rdy   = ~rdy_oe;

  modport conv (input cs_n, wr_n, rd_n, addr, output data, int_oe, rdy_oe);
  modport host (output cs_n, wr_n, rd_n, addr, input data, int_n, rdy);
endinterface : adc_bus_if
`default_nettype wire

// ===== src/adc_conv_ctl.sv
// Converter end: conversion sequencing, result read decode, open-drain outputs.
// Assumes synchronous bus strobes; the result value comes from the analog side.
// What this block and its host do
// - Start strobe low begins a new conversion
// - Finish within strobe width plus 46 clocks
// - Host spaces strobes past conversion and readout
// - Host spaces strobes in multiples of four
// - Host spaces strobes at least 50 clocks
// - Simple host divides clock by 64
// - Timer host may divide clock by 52
// - Host reads only after conversion completes
// - Host may wait fixed delay before reading
// - Interrupt pulled low when conversion finishes
// - Byte variant offers readable done flag
// - Word variant: write to address starts conversion
// - Word variant: read same address gives result
// - Byte variant: base plus one gives top bits
// - Byte variant: base gives low eight bits
// - Ready and interrupt are open-drain outputs
// - Host strobe synchronous with conversion clock
`timescale 1ns/1ps
`default_nettype none
module adc_conv_ctl
  import adc_ctl_pkg::*;
#(
  parameter bit BYTE_SPLIT = 1'b0   // 1: 8+2 byte reads, 0: one word
) (
  // Clock, reset, enable
  input  wire logic                ref_clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                clk_en_in,
  // Sampled analog result
  input  wire logic [RESULT_W-1:0] sample_in,
  // Host bus
  adc_bus_if.conv                  bus,
  // Status for the user side
  output logic                     busy_out
);
  typedef enum logic [1:0] {IDLE, STROBE, CONVERT} conv_e;

  conv_e                conv_q, conv_d;
  logic [CNT_W-1:0]     cnt_q, cnt_d;
  logic [RESULT_W-1:0]  result_q, result_d;
  logic                 done_q, done_d;
  logic [RESULT_W-1:0]  data_q, data_d;
  logic                 busy_q, busy_d;
  logic                 start_w, read_w;

  // One step down the conversion count
  function automatic logic [CNT_W-1:0] cnt_dec(input logic [CNT_W-1:0] v);
    cnt_dec = v - CNT_W'(1);
  endfunction : cnt_dec

  // Strobes count only while selected
  assign start_w = ~bus.cs_n & ~bus.wr_n;
  assign read_w  = ~bus.cs_n & ~bus.rd_n;

  // Sequencer: the count runs from the strobe's rising edge, so a long strobe
  // stretches the conversion exactly as much as its own width
  always_comb begin
    conv_d   = conv_q;
    cnt_d    = cnt_q;
    result_d = result_q;
    done_d   = done_q;
    busy_d   = busy_q;
    case (conv_q)
      IDLE: begin
        if (start_w) begin
          conv_d = STROBE;
          cnt_d  = CNT_W'(CONV_CLKS - 1);
          done_d = 1'b0;
          busy_d = 1'b1;
        end
      end
      // The release edge is the first of the counted clocks, so the done edge
      // lands within strobe width plus the conversion budget
      STROBE: begin
        if (!start_w) begin
          conv_d = CONVERT;
          cnt_d  = cnt_dec(cnt_q);
        end
      end
      CONVERT: begin
        if (cnt_q == '0) begin
          conv_d   = IDLE;
          result_d = sample_in;
          done_d   = 1'b1;
          busy_d   = 1'b0;
        end else begin
          cnt_d = cnt_dec(cnt_q);
        end
      end
      default: conv_d = IDLE;
    endcase
    // Reading any data clears the interrupt; a new done wins over it
    if (read_w && done_q && !(conv_q == CONVERT && cnt_q == '0)) begin
      done_d = 1'b0;
    end
  end

  // Read decode registered, so data follows the read strobe by one clock
  always_comb begin
    data_d = '0;
    if (read_w) begin
      if (!BYTE_SPLIT) begin
        data_d = result_q;
      end else if (bus.addr == ADDR_BASE) begin
        data_d = {{HIGH_W{1'b0}}, result_q[LOW_W-1:0]};
      end else begin
        data_d = RESULT_W'({~busy_q, 5'h00, result_q[RESULT_W-1:LOW_W]});
      end
    end
  end

  // State registers, frozen while the clock enable is low
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      conv_q   <= IDLE;
      cnt_q    <= '0;
      result_q <= '0;
      done_q   <= 1'b0;
      data_q   <= '0;
      busy_q   <= 1'b0;
    end else if (clk_en_in) begin
      conv_q   <= conv_d;
      cnt_q    <= cnt_d;
      result_q <= result_d;
      done_q   <= done_d;
      data_q   <= data_d;
      busy_q   <= busy_d;
    end
  end

  // Open-drain drives: enable high means the pin is pulled low
  assign bus.int_oe = done_q;
  assign bus.rdy_oe = busy_q;
  assign bus.data   = data_q;
  assign busy_out   = busy_q;
endmodule : adc_conv_ctl
`default_nettype wire

// ===== src/adc_host_ctl.sv
// Host end: periodic start strobes from a clock divider, result readout.
// Assumes the converter shares ref_clk_in as its conversion clock.
`timescale 1ns/1ps
`default_nettype none
module adc_host_ctl
  import adc_ctl_pkg::*;
#(
  parameter int unsigned DIVIDE     = DIV_SIMPLE, // 64, or 52 from a timer
  parameter bit          BYTE_SPLIT = 1'b0
) (
  // Clock, reset, enable
  input  wire logic                ref_clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                clk_en_in,
  input  wire logic                run_in,
  // Bus to the converter
  adc_bus_if.host                  bus,
  // Results to the user
  output logic [RESULT_W-1:0]      sample_out,
  output logic                     sample_vld_out
);
  typedef enum logic [2:0] {WAIT, RD_LO, RD_HI, RD_GAP, DONE} host_e;

  host_e               st_q, st_d;
  logic [CNT_W-1:0]    div_q, div_d;
  logic                wr_q, wr_d, rd_q, rd_d, cs_q, cs_d, addr_q, addr_d;
  logic [RESULT_W-1:0] smp_q, smp_d;
  logic                vld_q, vld_d;

  // Divider fires a one-clock strobe every DIVIDE clocks, which keeps the
  // spacing fixed, a multiple of four and above the least spacing
  always_comb begin
    div_d = (div_q == CNT_W'(DIVIDE - 1)) ? '0 : div_q + CNT_W'(1);
    if (!run_in) div_d = '0;
  end

  // Bus sequencer: start, wait for the interrupt, then read
  always_comb begin
    st_d   = st_q;
    wr_d   = 1'b0;
    rd_d   = 1'b0;
    cs_d   = 1'b0;
    addr_d = ADDR_BASE;
    smp_d  = smp_q;
    vld_d  = 1'b0;
    if (run_in && div_q == '0) begin
      wr_d = 1'b1;
      cs_d = 1'b1;
      st_d = WAIT;
    end else begin
      case (st_q)
        WAIT: if (!bus.int_n) begin
          st_d = RD_LO;
          rd_d = 1'b1;
          cs_d = 1'b1;
        end
        RD_LO: begin
          if (BYTE_SPLIT) begin
            st_d   = RD_HI;
            rd_d   = 1'b1;
            cs_d   = 1'b1;
            addr_d = ADDR_HIGH;
          end else begin
            // Converter data is registered, so take it one clock later
            st_d = RD_GAP;
          end
        end
        RD_HI: begin
          st_d  = RD_GAP;
          smp_d = {smp_q[RESULT_W-1:LOW_W], bus.data[LOW_W-1:0]};
        end
        RD_GAP: begin
          st_d  = DONE;
          vld_d = 1'b1;
          if (BYTE_SPLIT) begin
            smp_d = {bus.data[HIGH_W-1:0], smp_q[LOW_W-1:0]};
          end else begin
            smp_d = bus.data;
          end
        end
        DONE:    st_d = DONE;
        default: st_d = DONE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      st_q   <= DONE;
      div_q  <= '0;
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      cs_q   <= 1'b0;
      addr_q <= 1'b0;
      smp_q  <= '0;
      vld_q  <= 1'b0;
    end else if (clk_en_in) begin
      st_q   <= st_d;
      div_q  <= div_d;
      wr_q   <= wr_d;
      rd_q   <= rd_d;
      cs_q   <= cs_d;
      addr_q <= addr_d;
      smp_q  <= smp_d;
      vld_q  <= vld_d;
    end
  end

  assign bus.wr_n       = ~wr_q;
  assign bus.rd_n       = ~rd_q;
  assign bus.cs_n       = ~cs_q;
  assign bus.addr       = addr_q;
  assign sample_out     = smp_q;
  assign sample_vld_out = vld_q;
endmodule : adc_host_ctl
`default_nettype wire

// ===== dv/adc_link_monitor.sv
// Checker on the shared bus: start, ready, interrupt and read data timing.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module adc_link_monitor (
  // Clock, reset
  input wire logic       ref_clk_in,
  input wire logic       rst_n_in,
  // Bus
  input wire logic       cs_n,
  input wire logic       wr_n,
  input wire logic       rd_n,
  input wire logic [9:0] data,
  input wire logic       int_oe,
  input wire logic       rdy_oe
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // A start counts only while idle, so a busy converter never restarts
  sequence start_taken;
    !cs_n && !wr_n && !rdy_oe && !int_oe;
  endsequence
  sequence read_cycle;
    !cs_n && !rd_n;
  endsequence
  chk_start_busy: assert property (start_taken |=> rdy_oe)
    else $error("start not taken");
  chk_conv_time: assert property (start_taken ##1 wr_n |-> ##46 $rose(int_oe))
    else $error("conversion late");
  chk_done_ready: assert property ($rose(int_oe) |-> $fell(rdy_oe))
    else $error("ready held after done");
  chk_busy_quiet: assert property (rdy_oe |-> !int_oe)
    else $error("interrupt while busy");
  chk_int_hold: assert property (int_oe && (cs_n || rd_n) |=> int_oe)
    else $error("interrupt dropped early");
  chk_read_clear: assert property (int_oe ##0 read_cycle |=> !int_oe)
    else $error("interrupt not cleared");
  chk_idle_data: assert property ((cs_n || rd_n) |=> data == 10'h000)
    else $error("data without read");
  chk_cs_ignore: assert property (cs_n && !rdy_oe && !int_oe |=> !rdy_oe)
    else $error("start without select");
endmodule : adc_link_monitor
`default_nettype wire

// ===== dv/sampling_adc_bus_control_tb_top.sv
// Bench: host and converter pairs face each other; a byte converter is driven by tasks.
// Assumes the shared 50 MHz clock and synchronous active-low reset of both ends.
`timescale 1ns/1ps
`default_nettype none
module sampling_adc_bus_control_tb_top;
  import adc_ctl_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       run = 1'b0;
  logic [9:0] smp_a = 10'h2a5;
  logic [9:0] smp_b = 10'h2c7;
  logic [9:0] smp_out;
  logic [9:0] rd;
  logic       vld;
  logic       busy_b;
  logic       ce_b = 1'b1;
  logic [9:0] smp_c;
  logic       vld_c;
  localparam int FREEZE = 8;       // Clocks the byte converter is held frozen
  int         failures = 0;
  int         num_checks = 0;
  int         n;
  adc_bus_if bus_a ();
  adc_bus_if bus_b ();
  adc_bus_if bus_c ();
  // 50 MHz clock
  always #10 clk = ~clk;
  adc_host_ctl #(.DIVIDE(DIV_TIMER), .BYTE_SPLIT(1'b0)) u_adc_host_ctl (.ref_clk_in(clk),
    .rst_n_in(rst_n), .clk_en_in(1'b1), .run_in(run), .bus(bus_a), .sample_out(smp_out),
    .sample_vld_out(vld));
  adc_conv_ctl #(.BYTE_SPLIT(1'b0)) u_adc_conv_ctl (.ref_clk_in(clk), .rst_n_in(rst_n),
    .clk_en_in(1'b1), .sample_in(smp_a), .bus(bus_a), .busy_out());
  // Second converter: the bench plays host so it can break the select rule
  adc_conv_ctl #(.BYTE_SPLIT(1'b1)) u_adc_conv_ctl_byte (.ref_clk_in(clk), .rst_n_in(rst_n),
    .clk_en_in(ce_b), .sample_in(smp_b), .bus(bus_b), .busy_out(busy_b));
  // Third pair: byte host against byte converter
  adc_host_ctl #(.DIVIDE(DIV_SIMPLE), .BYTE_SPLIT(1'b1)) u_adc_host_ctl_byte (.ref_clk_in(clk),
    .rst_n_in(rst_n), .clk_en_in(1'b1), .run_in(run), .bus(bus_c), .sample_out(smp_c),
    .sample_vld_out(vld_c));
  adc_conv_ctl #(.BYTE_SPLIT(1'b1)) u_adc_conv_ctl_pair (.ref_clk_in(clk), .rst_n_in(rst_n),
    .clk_en_in(1'b1), .sample_in(smp_b), .bus(bus_c), .busy_out());
  adc_link_monitor u_adc_link_monitor (.ref_clk_in(clk), .rst_n_in(rst_n), .cs_n(bus_a.cs_n),
    .wr_n(bus_a.wr_n), .rd_n(bus_a.rd_n), .data(bus_a.data), .int_oe(bus_a.int_oe),
    .rdy_oe(bus_a.rdy_oe));
  task check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
    end
  endtask : check
  // One-cycle start strobe; sel_n high makes a strobe the converter must ignore
  task bus_write(input logic sel_n);
    @(posedge clk);
    bus_b.cs_n <= sel_n;
    bus_b.wr_n <= 1'b0;
    @(posedge clk);
    bus_b.cs_n <= 1'b1;
    bus_b.wr_n <= 1'b1;
  endtask : bus_write
  // Data is a register, so it is taken half a cycle after the strobe edge
  task bus_read(input logic a, output logic [9:0] d);
    @(posedge clk);
    bus_b.cs_n <= 1'b0;
    bus_b.rd_n <= 1'b0;
    bus_b.addr <= a;
    @(posedge clk);
    bus_b.cs_n <= 1'b1;
    bus_b.rd_n <= 1'b1;
    @(negedge clk);
    d = bus_b.data;
  endtask : bus_read
  task wait_vld(output int k);
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (vld !== 1'b1 && k < 200);
  endtask : wait_vld
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict
  // Watchdog: the tests need a few hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    print_verdict();
  end
  initial begin
    bus_b.cs_n = 1'b1;
    bus_b.wr_n = 1'b1;
    bus_b.rd_n = 1'b1;
    bus_b.addr = 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    run <= 1'b1;
    wait_vld(n);
    check(vld, 1'b1);
    check(smp_out, 10'h2a5);
    smp_a <= 10'h15a;
    wait_vld(n);
    check(n, DIV_TIMER);
    check(n % SPACING_STEP, 0);
    check(n >= MIN_SPACING, 1);
    check(smp_out, 10'h15a);
    $display("test word_pair done");
    // Byte host splices the two byte reads into one word
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (vld_c !== 1'b1 && n < 200);
    check(vld_c, 1'b1);
    check(smp_c, 10'h2c7);
    $display("test byte_pair done");
    bus_write(1'b1);
    repeat (2) @(negedge clk);
    check(busy_b, 1'b0);
    bus_write(1'b0);
    @(negedge clk);
    check(busy_b, 1'b1);
    bus_read(ADDR_HIGH, rd);
    check(rd, 10'h000);
    // Clock enable low freezes the converter: the conversion stretches by as much
    @(posedge clk);
    ce_b <= 1'b0;
    repeat (FREEZE) @(posedge clk);
    ce_b <= 1'b1;
    // n counts clocks since the strobe was released
    n = FREEZE + 2;
    while (bus_b.int_n !== 1'b0 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check(n, CONV_CLKS + FREEZE);
    check(bus_b.int_n, 1'b0);
    bus_read(ADDR_HIGH, rd);
    check(rd, {3'b001, 5'b00000, smp_b[9:8]});
    check(bus_b.int_n, 1'b1);
    bus_read(ADDR_BASE, rd);
    check(rd, {2'b00, smp_b[7:0]});
    $display("test byte_end done");
    // Fixed wait past the conversion time instead of polling
    smp_b <= 10'h13c;
    bus_write(1'b0);
    repeat (CONV_CLKS + READ_CLKS) @(posedge clk);
    bus_read(ADDR_BASE, rd);
    check(rd, {2'h0, 8'h3c});
    bus_read(ADDR_HIGH, rd);
    check(rd, {3'h1, 5'h00, 2'h1});
    $display("test fixed_delay done");
    print_verdict();
  end
endmodule : sampling_adc_bus_control_tb_top
`default_nettype wire
